// ### rtl/ddcs_pkg.sv
package ddcs_pkg;

  // ---------------------------------------------------------------
  // Frame and word layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned CNT_W       = 5;
  localparam logic [4:0]  FRAME_BITS  = 5'h18;
  localparam logic [4:0]  CNT_SAT     = 5'h19;

  // Control word zero fields
  localparam int unsigned CTL_SEL_BIT   = 0;
  localparam int unsigned CTL_LS1_BIT   = 1;
  localparam int unsigned CTL_HS1_BIT   = 2;
  localparam int unsigned CTL_LS2_BIT   = 3;
  localparam int unsigned CTL_HS2_BIT   = 4;
  localparam int unsigned CTL_LS3_BIT   = 5;
  localparam int unsigned CTL_HS3_BIT   = 6;
  localparam int unsigned CTL_LOCK_BIT  = 20;
  localparam int unsigned CTL_DUTY_BIT  = 21;
  localparam int unsigned CTL_CLR_BIT   = 22;
  localparam int unsigned CTL_EN_BIT    = 23;
  localparam logic        CTL_SEL_WORD0 = 1'h0;

  // Retry duty encodings carried by the duty bit, in percent
  localparam int unsigned DUTY_LOW_PCT  = 12;
  localparam int unsigned DUTY_HIGH_PCT = 25;

  // Status word zero fields
  localparam int unsigned ST_NOERR_BIT = 0;
  localparam int unsigned ST_TSD_BIT   = 20;
  localparam int unsigned ST_UV_BIT    = 21;
  localparam int unsigned ST_OV_BIT    = 22;
  localparam int unsigned ST_ONE_BIT   = 23;

  // ---------------------------------------------------------------
  // Synchroniser lanes
  // ---------------------------------------------------------------
  localparam int unsigned SY_W    = 9;
  localparam int unsigned SY_SCLK = 0;
  localparam int unsigned SY_CSN  = 1;
  localparam int unsigned SY_DI   = 2;
  localparam int unsigned SY_PW1  = 3;
  localparam int unsigned SY_PW2  = 4;
  localparam int unsigned SY_TEST = 5;
  localparam int unsigned SY_OV   = 6;
  localparam int unsigned SY_UV   = 7;
  localparam int unsigned SY_TSD  = 8;

  // ---------------------------------------------------------------
  // Test output source selection, index {pair3, pair2, pair1}
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DDCS_TSEL_NOERR = 3'h0,
    DDCS_TSEL_DI    = 3'h1,
    DDCS_TSEL_SCLK  = 3'h2,
    DDCS_TSEL_ICLK  = 3'h3,
    DDCS_TSEL_PW1   = 3'h4,
    DDCS_TSEL_PW2   = 3'h5
  } ddcs_tsel_e;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned ICLK_HALF_NS     = 250;
  localparam int unsigned ICLK_HALF_CYC    = (ICLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                             ICLK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned ICLK_CNT_W       = 4;

endpackage : ddcs_pkg

// ### rtl/ddcs_sync.sv
`timescale 1ns/1ps

module ddcs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ---------------------------------------------------------------
  // Two flops per lane; the first is read only by the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : ddcs_sync

// ### rtl/ddcs_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Enable bit set: enter active mode
// - Enable bit clear: standby, clear everything
// - After power-on reset start in standby
// - Reset bit clears status at frame end
// - Duty bit selects 12% or 25% retry
// - Lock-out bit holds outputs off until cleared
// - Status bit 23 always reads one
// - Supply over/under-voltage sets bit in active mode, outputs off
// - Supply normal, no lock-out: outputs back on
// - Thermal shutdown sets bit in active mode, outputs stay off
// - Latch only frames of exactly 24 pulses
// - Test mode: bridge pairs select data-out source

module ddcs_ctrl
  import ddcs_pkg::*;
#(
  parameter int unsigned ICLK_HALF = ICLK_HALF_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              serial_clock_i,
  input  wire logic              chip_select_low_i,
  input  wire logic              serial_in_pin_i,
  input  wire logic              pulse_input_one_i,
  input  wire logic              pulse_input_two_i,
  input  wire logic              test_mode_i,
  input  wire logic              supply_over_i,
  input  wire logic              supply_under_i,
  input  wire logic              thermal_trip_i,
  output logic                   serial_out_o,
  output logic                   serial_out_en_o,
  output logic                   active_mode_o,
  output logic                   outputs_enable_o,
  output logic                   retry_duty_high_o,
  output logic                   supply_lockout_o,
  output logic [WORD_W-1:0]      control_word_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (ICLK_HALF < 1 || ICLK_HALF >= (1 << ICLK_CNT_W))
  begin : g_bad_iclk
    $error("ICLK_HALF must lie between 1 and 15");
  end

  if (FRAME_BITS != WORD_W)
  begin : g_bad_frame
    $error("FRAME_BITS must equal WORD_W");
  end

  if (CNT_SAT != FRAME_BITS + 1)
  begin : g_bad_sat
    $error("CNT_SAT must be one above FRAME_BITS");
  end

  if ((1 << CNT_W) <= CNT_SAT)
  begin : g_bad_cnt
    $error("CNT_W too narrow for the saturating pulse count");
  end

  if (CNT_W != $bits(FRAME_BITS))
  begin : g_bad_cnt_w
    $error("CNT_W must match the width of FRAME_BITS");
  end

  if (CTL_EN_BIT >= WORD_W || ST_ONE_BIT >= WORD_W)
  begin : g_bad_field
    $error("Control or status field lies outside the word");
  end

  // Bridge bits must stay clear of the mode bits, or a test selection would change the mode
  if (CTL_HS3_BIT >= CTL_LOCK_BIT)
  begin : g_bad_bridge
    $error("Bridge bits overlap the upper control fields");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0]     in_sr;
    logic [CNT_W-1:0]      bit_cnt;
    logic [WORD_W-1:0]     out_sr;
    logic                  loaded;
    logic [WORD_W-1:0]     ctrl;
    logic                  ov;
    logic                  uv;
    logic                  thermal_shutdown_flag;
    logic [ICLK_CNT_W-1:0] iclk_cnt;
    logic                  iclk;
    logic                  sclk_prev;
    logic                  csn_prev;
    logic                  dout;
    logic                  dout_en;
    logic                  out_en;
  } ddcs_state_s;

  ddcs_state_s q;
  ddcs_state_s d;

  logic [SY_W-1:0] sy;

  ddcs_sync #(
    .W (SY_W)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    // Chip select enters inverted so the lane resets to its idle level and no false frame follows reset
    .async_i   ({thermal_trip_i, supply_under_i, supply_over_i, test_mode_i,
                 pulse_input_two_i, pulse_input_one_i, serial_in_pin_i,
                 ~chip_select_low_i, serial_clock_i}),
    .sync_o    (sy)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] status_word(input logic ov, input logic uv, input logic thermal_shutdown_flag);
    logic [WORD_W-1:0] w;
    w               = '0;
    w[ST_ONE_BIT]   = 1'h1;
    w[ST_OV_BIT]    = ov;
    w[ST_UV_BIT]    = uv;
    w[ST_TSD_BIT]   = thermal_shutdown_flag;
    w[ST_NOERR_BIT] = ~(ov | uv | thermal_shutdown_flag);
    return w;
  endfunction : status_word

  function automatic logic pair_on(input logic [WORD_W-1:0] c, input int unsigned ls, input int unsigned hs);
    return c[ls] & c[hs];
  endfunction : pair_on

  logic             sclk_rise;
  logic             sclk_fall;
  logic             cs_fall;
  logic             cs_rise;
  logic             in_frame;
  logic             good_frame;
  logic [WORD_W-1:0] cur_status;
  ddcs_tsel_e       tsel;
  logic             tsrc;

  assign sclk_rise  = sy[SY_SCLK] & ~q.sclk_prev;
  assign sclk_fall  = ~sy[SY_SCLK] & q.sclk_prev;
  assign cs_fall    = sy[SY_CSN] & ~q.csn_prev;
  assign cs_rise    = ~sy[SY_CSN] & q.csn_prev;
  assign in_frame   = sy[SY_CSN];
  assign good_frame = cs_rise && (q.bit_cnt == FRAME_BITS)
                      && (q.in_sr[CTL_SEL_BIT] == CTL_SEL_WORD0);
  assign cur_status = status_word(q.ov, q.uv, q.thermal_shutdown_flag);

  // Pairs with both switches commanded cannot drive a load, so they double as selector
  always_comb
  begin
    tsel = ddcs_tsel_e'({pair_on(q.ctrl, CTL_LS3_BIT, CTL_HS3_BIT),
                         pair_on(q.ctrl, CTL_LS2_BIT, CTL_HS2_BIT),
                         pair_on(q.ctrl, CTL_LS1_BIT, CTL_HS1_BIT)});
    case (tsel)
      DDCS_TSEL_NOERR: tsrc = cur_status[ST_NOERR_BIT];
      DDCS_TSEL_DI:    tsrc = sy[SY_DI];
      DDCS_TSEL_SCLK:  tsrc = sy[SY_SCLK];
      DDCS_TSEL_ICLK:  tsrc = q.iclk;
      DDCS_TSEL_PW1:   tsrc = sy[SY_PW1];
      DDCS_TSEL_PW2:   tsrc = sy[SY_PW2];
      default:         tsrc = cur_status[ST_NOERR_BIT];
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d           = q;
    d.sclk_prev = sy[SY_SCLK];
    d.csn_prev  = sy[SY_CSN];

    // Free-running internal clock for test observation
    if (q.iclk_cnt == ICLK_CNT_W'(ICLK_HALF - 1))
    begin
      d.iclk_cnt = '0;
      d.iclk     = ~q.iclk;
    end
    else
    begin
      d.iclk_cnt = q.iclk_cnt + 1'h1;
    end

    // Serial shift in, LSB first
    if (cs_fall)
    begin
      d.bit_cnt = '0;
      d.loaded  = 1'h0;
    end
    else if (in_frame && sclk_rise)
    begin
      d.in_sr = {sy[SY_DI], q.in_sr[WORD_W-1:1]};
      if (q.bit_cnt != CNT_SAT)
      begin
        d.bit_cnt = q.bit_cnt + 1'h1;
      end
      // The first rising edge captures the status snapshot for this frame
      if (!q.loaded)
      begin
        d.out_sr = cur_status;
        d.loaded = 1'h1;
      end
    end
    else if (in_frame && sclk_fall && q.loaded)
    begin
      d.out_sr = {1'h0, q.out_sr[WORD_W-1:1]};
    end

    // Frame end: commit or ignore
    if (good_frame)
    begin
      d.ctrl = q.in_sr;
      if (!q.in_sr[CTL_EN_BIT])
      begin
        d.ctrl = '0;
        d.ov   = 1'h0;
        d.uv   = 1'h0;
        d.thermal_shutdown_flag  = 1'h0;
      end
      else if (q.in_sr[CTL_CLR_BIT])
      begin
        d.ov  = 1'h0;
        d.uv  = 1'h0;
        d.thermal_shutdown_flag = 1'h0;
      end
    end

    // In active mode events are recorded after any clear so that a coincident event survives it
    if (d.ctrl[CTL_EN_BIT])
    begin
      if (sy[SY_OV])
      begin
        d.ov = 1'h1;
      end
      if (sy[SY_UV])
      begin
        d.uv = 1'h1;
      end
      if (sy[SY_TSD])
      begin
        d.thermal_shutdown_flag = 1'h1;
      end
    end

    // Drivers are allowed only in active mode and with no fault holding them off
    d.out_en = d.ctrl[CTL_EN_BIT]
               & ~d.thermal_shutdown_flag
               & ~sy[SY_OV] & ~sy[SY_UV]
               & ~(d.ctrl[CTL_LOCK_BIT] & (d.ov | d.uv));

    // Data out: selected source in test mode; otherwise no-error flag until the first edge, then the snapshot
    if (sy[SY_TEST])
    begin
      d.dout    = tsrc;
      d.dout_en = 1'h1;
    end
    else
    begin
      d.dout    = d.loaded ? d.out_sr[0] : cur_status[ST_NOERR_BIT];
      d.dout_en = in_frame;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q           <= '0;
      q.sclk_prev <= 1'h0;
      q.csn_prev  <= 1'h0;
    end
    else
    begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign serial_out_o      = q.dout;
  assign serial_out_en_o   = q.dout_en;
  assign active_mode_o     = q.ctrl[CTL_EN_BIT];
  assign outputs_enable_o  = q.out_en;
  assign retry_duty_high_o = q.ctrl[CTL_DUTY_BIT];
  assign supply_lockout_o  = q.ctrl[CTL_LOCK_BIT];
  assign control_word_o    = q.ctrl;

endmodule : ddcs_ctrl

// ### sim/ddcs_ctrl_chk.sv
`timescale 1ns/1ps
module ddcs_ctrl_chk
  import ddcs_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              chip_select_low_i,
  input wire logic              test_mode_i,
  input wire logic              supply_over_i,
  input wire logic              thermal_trip_i,
  input wire logic              serial_out_en_o,
  input wire logic              active_mode_o,
  input wire logic              outputs_enable_o,
  input wire logic              retry_duty_high_o,
  input wire logic              supply_lockout_o,
  input wire logic [WORD_W-1:0] control_word_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ----
  // Steps
  // ----
  // Chip select rose two to five cycles back; commits may only land then
  sequence s_frame_end;
    $past(chip_select_low_i, 2) && (!$past(chip_select_low_i, 5) || !$past(chip_select_low_i, 6));
  endsequence
  sequence s_ov_held;
    supply_over_i [*5];
  endsequence
  sequence s_tsd_held;
    thermal_trip_i [*5];
  endsequence
  sequence s_test_held;
    test_mode_i [*5];
  endsequence
  AST_RST: assert property (disable iff (1'b0) sys_rst_i |=> !active_mode_o && control_word_o == '0)
    else $error("reset did not leave standby");
  AST_EN: assert property (active_mode_o == control_word_o[CTL_EN_BIT])
    else $error("active mode differs from enable bit");
  AST_STBY: assert property (!active_mode_o |-> control_word_o == '0)
    else $error("standby kept control bits");
  AST_DUTY: assert property (retry_duty_high_o == control_word_o[CTL_DUTY_BIT])
    else $error("duty output differs from duty bit");
  AST_LOCK: assert property (supply_lockout_o == control_word_o[CTL_LOCK_BIT])
    else $error("lock-out output differs from lock bit");
  AST_CW: assert property ($changed(control_word_o) |-> s_frame_end)
    else $error("control word changed outside frame end");
  AST_OFF: assert property (outputs_enable_o |-> active_mode_o)
    else $error("outputs enabled in standby");
  AST_OV: assert property (s_ov_held |-> !outputs_enable_o)
    else $error("outputs on during over-voltage");
  AST_TSD: assert property (s_tsd_held |-> !outputs_enable_o)
    else $error("outputs on during thermal trip");
  AST_TEST: assert property (s_test_held |-> serial_out_en_o)
    else $error("data out not driven in test mode");
endmodule : ddcs_ctrl_chk

// ### sim/ddcs_host.sv
`timescale 1ns/1ps
module ddcs_host (
  input  wire logic clk_i,
  input  wire logic serial_out_i,
  output logic      serial_clock_o,
  output logic      chip_select_low_o,
  output logic      serial_in_pin_o
);
  logic [23:0] rx_q;
  initial
  begin
    serial_clock_o    = 1'b0;
    chip_select_low_o = 1'b1;
    serial_in_pin_o   = 1'b0;
  end
  // ----
  // Mode-0 frame, LSB first; n pulses so short and long frames can be sent
  // ----
  task automatic frame(input logic [23:0] w, input int n);
    @(posedge clk_i);
    chip_select_low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      serial_in_pin_o <= w[i % 24];
      repeat (5) @(posedge clk_i);
      if (i < 24)
        rx_q[i] = serial_out_i;
      serial_clock_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      serial_clock_o <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    chip_select_low_o <= 1'b1;
    // Released line shows the inverse so a stale bit is never taken as valid
    serial_in_pin_o <= ~serial_in_pin_o;
    repeat (8) @(posedge clk_i);
  endtask : frame
  task automatic lines(input logic c, input logic d);
    serial_clock_o  <= c;
    serial_in_pin_o <= d;
  endtask : lines
endmodule : ddcs_host

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  import ddcs_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        sclk, chip_select_low, di, pw1 = 1'b0, pw2 = 1'b0, tmode = 1'b0, ov = 1'b0, uv = 1'b0, thermal_shutdown_flag = 1'b0;
  logic        sdo, sdo_en, act, oen, duty, lock;
  logic [23:0] cw, w;
  logic [31:0] rng = 32'hEF35;
  int          fails = 0;
  int          compares = 0;
  int          tg;
  logic        prv;
  localparam int unsigned TB_ICLK = 2;
  always #20 clk_i = ~clk_i;
  ddcs_ctrl #(.ICLK_HALF(TB_ICLK)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .serial_clock_i(sclk),
    .chip_select_low_i(chip_select_low), .serial_in_pin_i(di), .pulse_input_one_i(pw1), .pulse_input_two_i(pw2),
    .test_mode_i(tmode), .supply_over_i(ov), .supply_under_i(uv), .thermal_trip_i(thermal_shutdown_flag),
    .serial_out_o(sdo), .serial_out_en_o(sdo_en), .active_mode_o(act), .outputs_enable_o(oen),
    .retry_duty_high_o(duty), .supply_lockout_o(lock), .control_word_o(cw));
  ddcs_host host (.clk_i(clk_i), .serial_out_i(sdo), .serial_clock_o(sclk), .chip_select_low_o(chip_select_low),
    .serial_in_pin_o(di));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [23:0] st_exp(input logic o, input logic u, input logic t);
    return {1'b1, o, u, t, 19'h0, ~(o | u | t)};
  endfunction : st_exp
  // Sources differ per pattern so a wrong selection cannot match
  function automatic logic t_exp(input int s, input logic [1:0] v);
    case (s)
      1: return v[0];
      2: return v[1];
      4: return v[0] ^ v[1];
      5: return ~v[0];
      default: return 1'b1;
    endcase
  endfunction : t_exp
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic fault(input logic [2:0] f);
    @(posedge clk_i);
    {ov, uv, thermal_shutdown_flag} <= f;
    repeat (8) @(posedge clk_i);
    chk({23'h0, oen}, 24'h0);
    {ov, uv, thermal_shutdown_flag} <= 3'h0;
    repeat (8) @(posedge clk_i);
  endtask : fault
  task automatic report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #2000000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({22'h0, act, oen}, 24'h0);
    // ----
    // Random words, clear bit kept low so status stays put
    // ----
    for (int k = 0; k < 6; k++)
    begin
      rng = xs(rng);
      w = (rng[23:0] | 24'h800000) & 24'hBFFFFE;
      host.frame(w, 24);
      chk(cw, w);
      chk({21'h0, act, duty, lock}, {21'h0, 1'b1, w[21], w[20]});
      chk(host.rx_q, st_exp(1'b0, 1'b0, 1'b0));
    end
    for (int n = 23; n <= 25; n += 2)
    begin
      host.frame(24'h800000, n);
      chk(cw, w);
    end
    host.frame(24'h800000, 24);
    fault(3'h4);
    chk({23'h0, oen}, 24'h1);
    host.frame(24'h800000, 24);
    chk(host.rx_q, st_exp(1'b1, 1'b0, 1'b0));
    host.frame(24'hC00000, 24);
    host.frame(24'h800000, 24);
    chk(host.rx_q, st_exp(1'b0, 1'b0, 1'b0));
    host.frame(24'h900000, 24);
    fault(3'h2);
    chk({23'h0, oen}, 24'h0);
    host.frame(24'hD00000, 24);
    chk({23'h0, oen}, 24'h1);
    fault(3'h1);
    chk({23'h0, oen}, 24'h0);
    host.frame(24'h900000, 24);
    chk(host.rx_q, st_exp(1'b0, 1'b0, 1'b1));
    host.frame(24'hC00000, 24);
    chk({23'h0, oen}, 24'h1);
    host.frame(24'h00007E, 24);
    chk({cw[23:1], act}, 24'h0);
    fault(3'h1);
    host.frame(24'h800000, 24);
    chk(host.rx_q, st_exp(1'b0, 1'b0, 1'b0));
    // ----
    // Test mode source selection; the internal clock is judged by its toggle count
    // ----
    for (int s = 0; s < 6; s++)
    begin
      w = 24'h800000 | (s[0] ? 24'h6 : 24'h0) | (s[1] ? 24'h18 : 24'h0) | (s[2] ? 24'h60 : 24'h0);
      host.frame(w, 24);
      tmode <= 1'b1;
      if (s == 3)
      begin
        repeat (6) @(posedge clk_i);
        tg = 0;
        prv = sdo;
        repeat (16)
        begin
          @(posedge clk_i);
          if (sdo !== prv)
            tg++;
          prv = sdo;
        end
        chk(24'(tg), 24'(16 / TB_ICLK));
      end
      else
      for (int v = 0; v < 4; v++)
      begin
        host.lines(v[1], v[0]);
        pw1 <= v[0] ^ v[1];
        pw2 <= ~v[0];
        repeat (6) @(posedge clk_i);
        chk({23'h0, sdo}, {23'h0, t_exp(s, v[1:0])});
      end
      tmode <= 1'b0;
      host.lines(1'b0, 1'b0);
      repeat (6) @(posedge clk_i);
    end
    report_and_stop();
  end
endmodule : tb
bind ddcs_ctrl ddcs_ctrl_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .chip_select_low_i(chip_select_low_i),
  .test_mode_i(test_mode_i), .supply_over_i(supply_over_i), .thermal_trip_i(thermal_trip_i),
  .serial_out_en_o(serial_out_en_o), .active_mode_o(active_mode_o), .outputs_enable_o(outputs_enable_o),
  .retry_duty_high_o(retry_duty_high_o), .supply_lockout_o(supply_lockout_o), .control_word_o(control_word_o));
